// ==== rtl/parallel_io_cfg.svh ====
`ifndef PARALLEL_IO_CFG_SVH
`define PARALLEL_IO_CFG_SVH
`define LINE_BASE_HI 24'hFFFF00
`define OFS_OWN_EN 8'h00
`define OFS_OWN_DIS 8'h04
`define OFS_OWN_STAT 8'h08
`define OFS_OE_SET 8'h10
`define OFS_OE_CLR 8'h14
`define OFS_OE_STAT 8'h18
`define OFS_FLT_SET 8'h20
`define OFS_FLT_CLR 8'h24
`define OFS_FLT_STAT 8'h28
`define OFS_DRV_SET 8'h30
`define OFS_DRV_CLR 8'h34
`define OFS_DRV_STAT 8'h38
`define OFS_LVL_STAT 8'h3C
`define OFS_IRQ_EN 8'h40
`define OFS_IRQ_DIS 8'h44
`define OFS_IRQ_MASK 8'h48
`define OFS_IRQ_STAT 8'h4C
`define RST_OWN 32'h01FFFFFF
`define RST_ZERO 32'h00000000
`define LINE_MASK 32'hFFFFFFFF
`endif

// ==== rtl/parallel_io_pkg.sv ====
`default_nettype none
package parallel_io_pkg;
    typedef logic [31:0] word_t;
    typedef struct packed {
        word_t s1;
        word_t s2;
        word_t s3;
        word_t level;
    } sampler_state_t;
    typedef struct packed {
        word_t own;
        word_t oe;
        word_t filt;
        word_t odsr;
        word_t imr;
        word_t isr;
        word_t prevLevel;
        logic primed;
        logic pready;
        logic pslverr;
        word_t prdata;
        word_t padOut;
        word_t padOe;
        word_t periphIn;
        logic irq;
    } ctrl_state_t;
endpackage
`default_nettype wire

// ==== rtl/line_bus_if.sv ====
`default_nettype none
interface line_bus_if;
    import parallel_io_pkg::*;
    word_t rawPins;
    word_t filterOn;
    word_t level;
    modport sampler (input rawPins, input filterOn, output level);
    modport ctrl (output rawPins, output filterOn, input level);
endinterface
`default_nettype wire

// ==== rtl/pin_sampler.sv ====
`default_nettype none
module pin_sampler
    import parallel_io_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Line side
    line_bus_if.sampler lines
);
    sampler_state_t st;
    sampler_state_t next_st;
    word_t stable;

    // Pad levels are data, not control: no reset, they follow the pins
    always_comb begin
        next_st = st;
        next_st.s1 = lines.rawPins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        stable = ~(st.s2 ^ st.s3);
        // A filtered line only moves after two equal samples
        next_st.level = (st.s2 & (~lines.filterOn | stable))
            | (st.level & lines.filterOn & ~stable);
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign lines.level = st.level;
endmodule
`default_nettype wire

// ==== rtl/parallel_line_controller.sv ====
// Implementation choice: the APB register port.
`default_nettype none
`include "parallel_io_cfg.svh"
module parallel_line_controller
    import parallel_io_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads
    input wire logic [31:0] padIn,
    output logic [31:0] padOut,
    output logic [31:0] padOe,
    // Multiplexed peripherals
    input wire logic [31:0] periphOut,
    input wire logic [31:0] periphOe,
    output logic [31:0] periphIn,
    // Interrupt
    output logic irq
);
    ctrl_state_t st;
    ctrl_state_t next_st;
    line_bus_if lines ();
    logic [7:0] ofs;
    logic inWindow;
    logic access;
    logic wrFire;
    logic rdFire;
    word_t wdata;
    word_t chg;
    word_t rdValue;
    logic known;

    pin_sampler u_sampler (
        .mclk(mclk),
        .lines(lines)
    );

    assign lines.rawPins = padIn;
    assign lines.filterOn = st.filt;

    assign ofs = paddr[7:0];
    assign inWindow = (paddr[31:8] == `LINE_BASE_HI) && (paddr[1:0] == 2'h0);
    assign access = psel && penable;
    // Writes and read side effects land only on the completing edge
    assign wrFire = access && st.pready && pwrite && inWindow;
    assign rdFire = access && st.pready && !pwrite && inWindow;
    assign wdata = pwdata & `LINE_MASK;

    // A level change on any line, whatever its owner or direction
    assign chg = st.primed ? (lines.level ^ st.prevLevel) : `RST_ZERO;

    // Read mux; unmapped and reserved words read zero
    always_comb begin
        rdValue = `RST_ZERO;
        known = 1'b1;
        case (ofs)
            `OFS_OWN_STAT: rdValue = st.own;
            `OFS_OE_STAT: rdValue = st.oe;
            `OFS_FLT_STAT: rdValue = st.filt;
            `OFS_DRV_STAT: rdValue = st.odsr;
            `OFS_LVL_STAT: rdValue = lines.level;
            `OFS_IRQ_MASK: rdValue = st.imr;
            // Include same-cycle changes so none slip past the clear
            `OFS_IRQ_STAT: rdValue = st.isr | chg;
            `OFS_OWN_EN, `OFS_OWN_DIS, `OFS_OE_SET, `OFS_OE_CLR,
            `OFS_FLT_SET, `OFS_FLT_CLR, `OFS_DRV_SET, `OFS_DRV_CLR,
            `OFS_IRQ_EN, `OFS_IRQ_DIS: rdValue = `RST_ZERO;
            default: begin
                rdValue = `RST_ZERO;
                known = 1'b0;
            end
        endcase
        rdValue = rdValue & `LINE_MASK;
        if (!inWindow) begin
            rdValue = `RST_ZERO;
        end
    end

    always_comb begin
        next_st = st;
        // One wait state: ready is high in the second access cycle
        next_st.pready = access && !st.pready;
        next_st.pslverr = access && !st.pready && !inWindow;
        if (access && !st.pready) begin
            next_st.prdata = pwrite ? `RST_ZERO : rdValue;
        end
        if (wrFire && known) begin
            case (ofs)
                `OFS_OWN_EN: next_st.own = st.own | wdata;
                `OFS_OWN_DIS: next_st.own = st.own & ~wdata;
                // Direction is kept even for peripheral-owned lines
                `OFS_OE_SET: next_st.oe = st.oe | wdata;
                `OFS_OE_CLR: next_st.oe = st.oe & ~wdata;
                `OFS_FLT_SET: next_st.filt = st.filt | wdata;
                `OFS_FLT_CLR: next_st.filt = st.filt & ~wdata;
                `OFS_DRV_SET: next_st.odsr = st.odsr | wdata;
                `OFS_DRV_CLR: next_st.odsr = st.odsr & ~wdata;
                `OFS_IRQ_EN: next_st.imr = st.imr | wdata;
                `OFS_IRQ_DIS: next_st.imr = st.imr & ~wdata;
                default: next_st.imr = st.imr;
            endcase
        end
        // Read clears, but a change in the same cycle still sets
        if (rdFire && ofs == `OFS_IRQ_STAT) begin
            next_st.isr = chg;
        end else begin
            next_st.isr = st.isr | chg;
        end
        next_st.prevLevel = lines.level;
        next_st.primed = 1'b1;
        // Pads are registered so every output comes from a flop
        next_st.padOe = (st.own & st.oe) | (~st.own & periphOe);
        next_st.padOut = (st.own & st.odsr) | (~st.own & periphOut);
        next_st.periphIn = lines.level & ~st.own;
        if (sys_rst) begin
            next_st.own = `RST_OWN;
            next_st.oe = `RST_ZERO;
            next_st.filt = `RST_ZERO;
            next_st.odsr = `RST_ZERO;
            next_st.imr = `RST_ZERO;
            next_st.isr = `RST_ZERO;
            next_st.primed = 1'b0;
            next_st.pready = 1'b0;
            next_st.pslverr = 1'b0;
            next_st.prdata = `RST_ZERO;
            next_st.padOut = `RST_ZERO;
            next_st.padOe = `RST_ZERO;
            next_st.periphIn = `RST_ZERO;
        end
        next_st.irq = !sys_rst && |(next_st.isr & next_st.imr);
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign padOut = st.padOut;
    assign padOe = st.padOe;
    assign periphIn = st.periphIn;
    assign irq = st.irq;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    property p_own_set;
        wrFire && ofs == `OFS_OWN_EN |=> (st.own & $past(wdata)) == $past(wdata);
    endproperty
    a_own_set: assert property (p_own_set)
        else $error("owner enable bits not set");

    property p_own_clr;
        wrFire && ofs == `OFS_OWN_DIS |=> (st.own & $past(wdata)) == 32'h0;
    endproperty
    a_own_clr: assert property (p_own_clr)
        else $error("owner disable bits not cleared");

    property p_periph_zero;
        !$past(sys_rst) |-> (periphIn & $past(st.own)) == 32'h0;
    endproperty
    a_periph_zero: assert property (p_periph_zero)
        else $error("owned line leaks to peripheral input");

    property p_pad_dir;
        ##1 !$past(sys_rst) |-> padOe ==
            (($past(st.own) & $past(st.oe)) | (~$past(st.own) & $past(periphOe)));
    endproperty
    a_pad_dir: assert property (p_pad_dir)
        else $error("pad direction mismatch");

    property p_oe_keep;
        wrFire && ofs == `OFS_OE_SET |=> ##1 (st.oe & $past(wdata, 2)) ==
            $past(wdata, 2) || $past(wrFire);
    endproperty
    a_oe_keep: assert property (p_oe_keep)
        else $error("output enable not stored");

    property p_oe_clr;
        wrFire && ofs == `OFS_OE_CLR |=> (st.oe & $past(wdata)) == 32'h0;
    endproperty
    a_oe_clr: assert property (p_oe_clr)
        else $error("output disable failed");

    property p_isr_rc;
        rdFire && ofs == `OFS_IRQ_STAT |=> st.isr == $past(chg);
    endproperty
    a_isr_rc: assert property (p_isr_rc)
        else $error("change status not cleared on read");

    property p_chg_set;
        chg != 32'h0 |=> (st.isr & $past(chg)) == $past(chg);
    endproperty
    a_chg_set: assert property (p_chg_set)
        else $error("level change lost");

    property p_irq;
        ##1 !$past(sys_rst) |-> irq == |(st.isr & st.imr);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output mismatch");

    property p_rsvd;
        rdFire && !known |-> prdata == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved offset read nonzero");

    property p_drv_set;
        wrFire && ofs == `OFS_DRV_SET |=> (st.odsr & $past(wdata)) == $past(wdata);
    endproperty
    a_drv_set: assert property (p_drv_set)
        else $error("drive set failed");

    c_own_write: cover property (wrFire && ofs == `OFS_OWN_EN);
    c_isr_read: cover property (rdFire && ofs == `OFS_IRQ_STAT && prdata != 32'h0);
    c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ==== sim/pad_world.sv ====
`default_nettype none
module pad_world
    import parallel_io_pkg::*;
(
    // Controller pad side
    input wire word_t padOut,
    input wire word_t padOe,
    // External circuit
    input wire word_t extVal,
    input wire word_t extEn,
    output word_t padIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Undriven lines sit on a pull-up, so a released pad never holds data
    // Pad follows the controller driver, else the external circuit
    assign padIn = (padOe & padOut) | (~padOe & ((extEn & extVal) | ~extEn));
endmodule
`default_nettype wire

// ==== sim/parallel_io_pin_control_tb.sv ====
`default_nettype none
module parallel_io_pin_control_tb;
    import parallel_io_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    word_t paddr = 0, pwdata = 0, periphOut = 0, periphOe = 0;
    word_t extVal = 0, extEn = 0;
    word_t prdata, padIn, padOut, padOe, periphIn;
    logic pready, pslverr, irq;
    int fails = 0, n_compared = 0, cycles = 0;
    int unsigned mOwn = 32'h01FFFFFF, mOe = 0, mFlt = 0, mDrv = 0;
    int unsigned mImr = 0, mIsr = 0, mLev, eOe, eOut;
    int unsigned wOfs[$] = '{'h00, 'h04, 'h10, 'h14, 'h20, 'h24, 'h30,
        'h34, 'h40, 'h44, 'h0C, 'h1C, 'h2C, 'h50, 'h08};
    word_t rd;
    logic err;
    always #12.5 mclk = ~mclk;
    parallel_line_controller DUT (.mclk(mclk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .periphOut(periphOut), .periphOe(periphOe), .periphIn(periphIn),
        .irq(irq));
    pad_world partner (.padOut(padOut), .padOe(padOe), .extVal(extVal),
        .extEn(extEn), .padIn(padIn));
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(string what, int unsigned exp, word_t got);
        n_compared++;
        if (got !== word_t'(exp)) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Master holds the whole request until pready is sampled high
    task automatic apb(logic w, word_t a, word_t d);
        int n;
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        n = 0;
        // Look between edges so the answer is never read in its launch step
        @(negedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 20) begin
            fails++;
            $display("FAIL pready expected 1 seen %b", pready);
        end
        rd = prdata;
        err = pslverr;
        // Completing edge: the write lands here, then the request drops
        @(posedge mclk);
        psel <= 0;
        penable <= 0;
    endtask
    function automatic int unsigned levelNow();
        eOe = (mOwn & mOe) | (~mOwn & periphOe);
        eOut = (mOwn & mDrv) | (~mOwn & periphOut);
        return (eOe & eOut) | (~eOe & ((extEn & extVal) | ~extEn));
    endfunction
    function automatic void mWrite(int unsigned a, int unsigned d);
        case (a)
            'h00: mOwn |= d;
            'h04: mOwn &= ~d;
            'h10: mOe |= d;
            'h14: mOe &= ~d;
            'h20: mFlt |= d;
            'h24: mFlt &= ~d;
            'h30: mDrv |= d;
            'h34: mDrv &= ~d;
            'h40: mImr |= d;
            'h44: mImr &= ~d;
            default: ; // Reserved and read-only places ignore writes
        endcase
    endfunction
    function automatic int unsigned mRead(int unsigned a);
        int unsigned v;
        case (a)
            'h08: v = mOwn;
            'h18: v = mOe;
            'h28: v = mFlt;
            'h38: v = mDrv;
            'h3C: v = mLev;
            'h48: v = mImr;
            'h4C: begin
                v = mIsr;
                mIsr = 0;
            end
            default: v = 0;
        endcase
        return v;
    endfunction
    // Lets the mux, synchroniser and filter settle, then logs the change
    task automatic settle();
        int unsigned l;
        repeat (9) @(posedge mclk);
        l = levelNow();
        mIsr |= l ^ mLev;
        mLev = l;
        chk("padOe", eOe, padOe);
        chk("padOut", eOut, padOut);
        chk("periphIn", mLev & ~mOwn, periphIn);
        chk("irq", {31'h0, |(mIsr & mImr)}, {31'h0, irq});
    endtask
    task automatic readAll();
        int unsigned e;
        for (int unsigned a = 0; a <= 'h50; a += 4) begin
            apb(0, 32'hFFFF0000 | a, 0);
            e = mRead(a);
            chk($sformatf("read %h", a), e, rd);
            chk("pslverr", 0, {31'h0, err});
        end
    endtask
    initial begin
        int unsigned k;
        int unsigned d;
        void'($urandom(68));
        repeat (10) @(posedge mclk);
        sys_rst <= 0;
        mLev = levelNow();
        settle();
        readAll();
        for (int i = 0; i < 80; i++) begin
            k = $urandom % 17;
            if (k < 15) begin
                d = $urandom;
                apb(1, 32'hFFFF0000 | wOfs[k], d);
                mWrite(wOfs[k], d);
            end else begin
                // Pads and peripheral move apart so a line toggles at most once per settle
                @(posedge mclk);
                extVal <= $urandom;
                extEn <= $urandom;
                settle();
                @(posedge mclk);
                periphOut <= $urandom;
                periphOe <= $urandom;
            end
            settle();
            readAll();
        end
        apb(1, 32'h00001000, 32'hFFFFFFFF);
        chk("pslverr window", 1, {31'h0, err});
        apb(1, 32'hFFFF0002, 32'hFFFFFFFF);
        chk("pslverr align", 1, {31'h0, err});
        settle();
        readAll();
        report_and_stop();
    end
endmodule
`default_nettype wire
